// ==== rtl/dces_regs.svh ====
`ifndef DCES_REGS_SVH
`define DCES_REGS_SVH
// Register byte address on the Wishbone bus
`define DCES_STATUS_ADDR 8'h00
// Field positions of the status register
`define DCES_CH1_EN_BIT 7
`define DCES_CH0_EN_BIT 6
`define DCES_CH1_GUARD_BIT 5
`define DCES_CH0_GUARD_BIT 4
`define DCES_CH1_IE_BIT 3
`define DCES_CH0_IE_BIT 2
`define DCES_SPARE_BIT 1
`define DCES_MAIN_EN_BIT 0
// Reset values and fixed read values
`define DCES_RESET_BIT 1'h0
`define DCES_SPARE_READ 1'h1
`define DCES_GUARD_READ 1'h1
`endif

// ==== rtl/dces_pkg.sv ====
package dces_pkg;
  // Progress of one bus access
  typedef enum logic [1:0] {
    DCES_IDLE = 2'b01,
    DCES_ACK = 2'b10
  } dces_bus_state_type;
endpackage

// ==== rtl/dces_chan_enable.sv ====
`timescale 1ns/10ps
`include "dces_regs.svh"
// One channel enable bit with its guarded write and terminal-count clear
module dces_chan_enable (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wr_i, // Register write strobe
  input wire logic guard_i, // Written guard bit value
  input wire logic data_i, // Written enable bit value
  input wire logic tc_i, // Byte counter reached zero
  output logic enable_o, // Channel enable bit
  output logic set_main_o // Guarded write of one
);
  logic guarded_wr;

  // Write counts only when the guard is written low
  assign guarded_wr = wr_i && !guard_i;
  assign set_main_o = guarded_wr && data_i;

  // Software write beats terminal count: a restart must not be lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_o <= `DCES_RESET_BIT; // [R14]
    end else if (guarded_wr) begin
      enable_o <= data_i;
    end else if (tc_i) begin
      enable_o <= 1'h0;
    end
  end
endmodule

// ==== rtl/dces_irq_gate.sv ====
`timescale 1ns/10ps
// Done request for one channel: enable low while its interrupt is enabled
module dces_irq_gate (
  input wire logic enable_i, // Channel enable bit
  input wire logic irq_en_i, // Channel interrupt enable
  output logic req_o // Channel done request
);
  // Level request, held as long as the channel sits disabled with its interrupt enabled
  assign req_o = !enable_i && irq_en_i;
endmodule

// ==== rtl/dces_status.sv ====
`timescale 1ns/10ps
`include "dces_regs.svh"
// Function
// R1: A channel may transfer only when its enable and main enable are set.
// R2: Channel 0 byte counter reaching zero clears the channel 0 enable.
// R3: Channel 0 enable low with its interrupt enable set requests an interrupt.
// R4: Channel 1 enable low with its interrupt enable set requests an interrupt.
// R5: Channel 0 enable changes only when its guard is written zero.
// R6: Channel 1 enable changes only when its guard is written zero.
// R7: Guarded write of zero to channel 0 enable stops channel 0.
// R8: Guarded write of one to channel 0 enable also sets main enable.
// R9: Guard bits never store a written zero; they read as one.
// R10: Channel 0 guard is write-only with no storage, always reads one.
// R11: Non-maskable interrupt clears the main enable.
// R12: Writing one to any enable, even if set, restarts via main enable.
// R13: Main enable is read-only; set by enable writes, cleared by NMI or reset.
// R14: Reset clears the channel 0 enable.
// R15: Reset clears the channel 1 interrupt enable.
// R16: Reset clears the channel 0 interrupt enable.
// R17: Reset clears the main enable.
// R18: Channel 1 byte counter reaching zero clears the channel 1 enable.
// R19: Guarded write to channel 1 enable sets or clears it; one sets main enable.
// R20: Bit 1 ignores writes and reads as a fixed value.
module dces_status
  import dces_pkg::*;
(
  input wire logic clk_i, // System clock, 40 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wb_err_o, // Wishbone error, unmapped address
  input wire logic nmi_i, // Non-maskable interrupt taken
  input wire logic chan0_tc_i, // Channel 0 byte counter reached zero
  input wire logic chan1_tc_i, // Channel 1 byte counter reached zero
  output logic chan0_run_o, // Channel 0 may transfer
  output logic chan1_run_o, // Channel 1 may transfer
  output logic dma_irq_o // DMA interrupt request to the CPU
);
  dces_bus_state_type bus_state;
  logic req;
  logic hit;
  logic wr;
  logic chan0_enable;
  logic chan1_enable;
  logic chan0_done_irq_enable;
  logic chan1_done_irq_enable;
  logic dma_master_enable;
  logic set0;
  logic set1;
  logic req0;
  logic req1;
  logic [7:0] status_rd;

  // New request only while idle, so every access sees exactly one answer
  assign req = wb_cyc_i && wb_stb_i && (bus_state == DCES_IDLE);
  assign hit = wb_adr_i == `DCES_STATUS_ADDR;
  assign wr = req && hit && wb_we_i && wb_sel_i[0];

  // One-wait-state slave: ack one cycle after the request, then drop it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= DCES_IDLE;
      wb_ack_o <= 1'h0;
      wb_err_o <= 1'h0;
    end else begin
      case (bus_state)
        DCES_IDLE: begin
          wb_ack_o <= req && hit;
          wb_err_o <= req && !hit;
          if (req) begin
            bus_state <= DCES_ACK;
          end
        end
        DCES_ACK: begin
          wb_ack_o <= 1'h0;
          wb_err_o <= 1'h0;
          bus_state <= DCES_IDLE;
        end
        default: begin
          wb_ack_o <= 1'h0;
          wb_err_o <= 1'h0;
          bus_state <= DCES_IDLE;
        end
      endcase
    end
  end

  // Channel enable bits with guarded writes
  // Both channels share one write strobe; each one looks at its own guard bit
  dces_chan_enable u_chan0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr),
    .guard_i(wb_dat_i[`DCES_CH0_GUARD_BIT]), // [R5] [R10]
    .data_i(wb_dat_i[`DCES_CH0_EN_BIT]), // [R7]
    .tc_i(chan0_tc_i), // [R2]
    .enable_o(chan0_enable),
    .set_main_o(set0)
  );
  dces_chan_enable u_chan1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr),
    .guard_i(wb_dat_i[`DCES_CH1_GUARD_BIT]), // [R6]
    .data_i(wb_dat_i[`DCES_CH1_EN_BIT]), // [R19]
    .tc_i(chan1_tc_i), // [R18]
    .enable_o(chan1_enable),
    .set_main_o(set1)
  );

  // Interrupt enables, plain read/write
  // No guard here: any write with lane 0 selected updates them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan0_done_irq_enable <= `DCES_RESET_BIT; // [R16]
      chan1_done_irq_enable <= `DCES_RESET_BIT; // [R15]
    end else if (wr) begin
      chan0_done_irq_enable <= wb_dat_i[`DCES_CH0_IE_BIT];
      chan1_done_irq_enable <= wb_dat_i[`DCES_CH1_IE_BIT];
    end
  end

  // Main enable: no direct write; NMI wins so service is never disturbed
  // Set and clear in one cycle: clearing is the safe side while NMI is serviced
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_master_enable <= `DCES_RESET_BIT; // [R17]
    end else if (nmi_i) begin
      dma_master_enable <= 1'h0; // [R11] [R13]
    end else if (set0 || set1) begin
      dma_master_enable <= 1'h1; // [R8] [R12] [R19]
    end
  end

  // Run permission per channel
  assign chan0_run_o = chan0_enable && dma_master_enable; // [R1]
  assign chan1_run_o = chan1_enable && dma_master_enable; // [R1]

  // Termination requests merged onto one line
  dces_irq_gate u_irq0 (
    .enable_i(chan0_enable),
    .irq_en_i(chan0_done_irq_enable),
    .req_o(req0) // [R3]
  );
  dces_irq_gate u_irq1 (
    .enable_i(chan1_enable),
    .irq_en_i(chan1_done_irq_enable),
    .req_o(req1) // [R4]
  );
  assign dma_irq_o = req0 || req1; // [R3] [R4]

  // Read image: guards and spare bit are constants, never stored
  // Reads have no side effects, so software may poll freely
  always_comb begin
    status_rd = 8'h00;
    status_rd[`DCES_CH1_EN_BIT] = chan1_enable;
    status_rd[`DCES_CH0_EN_BIT] = chan0_enable;
    status_rd[`DCES_CH1_GUARD_BIT] = `DCES_GUARD_READ; // [R9]
    status_rd[`DCES_CH0_GUARD_BIT] = `DCES_GUARD_READ; // [R10]
    status_rd[`DCES_CH1_IE_BIT] = chan1_done_irq_enable;
    status_rd[`DCES_CH0_IE_BIT] = chan0_done_irq_enable;
    status_rd[`DCES_SPARE_BIT] = `DCES_SPARE_READ; // [R20]
    status_rd[`DCES_MAIN_EN_BIT] = dma_master_enable;
  end

  // Read data registered with the ack; zero otherwise
  // Zero between answers keeps any shared read mux free of stale bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && hit && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, status_rd};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Checks
  sequence s_guarded_set0;
    wr && !wb_dat_i[`DCES_CH0_GUARD_BIT] && wb_dat_i[`DCES_CH0_EN_BIT];
  endsequence
  sequence s_guarded_set1;
    wr && !wb_dat_i[`DCES_CH1_GUARD_BIT] && wb_dat_i[`DCES_CH1_EN_BIT];
  endsequence
  sequence s_guarded_clr0;
    wr && !wb_dat_i[`DCES_CH0_GUARD_BIT] && !wb_dat_i[`DCES_CH0_EN_BIT];
  endsequence
  sequence s_guarded_clr1;
    wr && !wb_dat_i[`DCES_CH1_GUARD_BIT] && !wb_dat_i[`DCES_CH1_EN_BIT];
  endsequence
  // Write of one to the main enable position with both guards high
  sequence s_direct_main;
    wr && wb_dat_i[`DCES_MAIN_EN_BIT] && wb_dat_i[`DCES_CH0_GUARD_BIT]
    && wb_dat_i[`DCES_CH1_GUARD_BIT];
  endsequence
  // Request taken by the bus logic, mapped or not
  sequence s_taken_mapped;
    req && hit;
  endsequence
  sequence s_taken_unmapped;
    req && !hit;
  endsequence

  a_run_needs_both: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    chan0_run_o |-> (chan0_enable && dma_master_enable)) else $error("run without enables");
  a_tc_clears_ch0: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (chan0_tc_i && !wr) |=> !chan0_enable) else $error("ch0 not cleared on tc");
  a_irq_ch0_req: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (!chan0_enable && chan0_done_irq_enable) |-> dma_irq_o) else $error("ch0 irq missing");
  a_irq_ch1_req: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (!chan1_enable && chan1_done_irq_enable) |-> dma_irq_o) else $error("ch1 irq missing");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (!chan0_done_irq_enable && !chan1_done_irq_enable) |-> !dma_irq_o)
    else $error("irq without enable");
  a_guard_holds_ch0: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (wr && wb_dat_i[`DCES_CH0_GUARD_BIT] && !chan0_tc_i) |=> $stable(chan0_enable))
    else $error("ch0 changed without guard");
  a_guard_holds_ch1: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (wr && wb_dat_i[`DCES_CH1_GUARD_BIT] && !chan1_tc_i) |=> $stable(chan1_enable))
    else $error("ch1 changed without guard");
  a_set0_main: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (s_guarded_set0 ##0 !nmi_i) |=> (chan0_enable && dma_master_enable && wb_ack_o))
    else $error("ch0 set did not raise main enable");
  a_set1_main: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    (s_guarded_set1 ##0 !nmi_i) |=> (chan1_enable && dma_master_enable))
    else $error("ch1 set did not raise main enable");
  a_guard_reads_one: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (req && hit && !wb_we_i) |=> (wb_ack_o && wb_dat_o[5:4] == 2'h3 && wb_dat_o[1]))
    else $error("guard or spare read wrong");
  a_nmi_clears_main: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    nmi_i |=> !dma_master_enable && !chan0_run_o && !chan1_run_o)
    else $error("nmi did not stop dma");
  a_main_rises_only: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    $rose(dma_master_enable) |-> $past(set0 || set1)) else $error("main enable set directly");
  a_reset_clears: assert property (@(posedge clk_i) // [R14] [R17]
    rst_i |=> !chan0_enable && !chan1_enable && !dma_master_enable
    && !chan0_done_irq_enable && !chan1_done_irq_enable) else $error("reset values wrong");

  // Channel 1 run, guarded clears and interrupt enables
  a_run1_needs_both: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    chan1_run_o |-> (chan1_enable && dma_master_enable)) else $error("ch1 run without enables");
  a_clear0_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    s_guarded_clr0 |=> (!chan0_enable && !chan0_run_o))
    else $error("ch0 clear write ignored");
  a_clear1_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    s_guarded_clr1 |=> (!chan1_enable && !chan1_run_o))
    else $error("ch1 clear write ignored");
  a_irq_off_both: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    ((chan0_enable || !chan0_done_irq_enable) && (chan1_enable || !chan1_done_irq_enable))
    |-> !dma_irq_o) else $error("irq while no channel is done");
  a_irq_en_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R3] [R4]
    wr |=> (chan0_done_irq_enable == $past(wb_dat_i[`DCES_CH0_IE_BIT])
    && chan1_done_irq_enable == $past(wb_dat_i[`DCES_CH1_IE_BIT])))
    else $error("irq enable write lost");

  // Main enable: direct writes, restart and priorities
  a_main_no_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (s_direct_main ##0 !dma_master_enable) |=> !dma_master_enable)
    else $error("main enable written directly");
  a_restart_main: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (s_guarded_set0 ##0 (chan0_enable && !dma_master_enable && !nmi_i)) |=> dma_master_enable)
    else $error("restart did not set main enable");
  a_write_beats_tc: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (s_guarded_set0 ##0 chan0_tc_i) |=> chan0_enable) else $error("tc beat a channel write");
  a_nmi_beats_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (s_guarded_set0 ##0 nmi_i) |=> !dma_master_enable) else $error("set beat nmi");
  a_main_holds: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (!nmi_i && !set0 && !set1) |=> $stable(dma_master_enable))
    else $error("main enable moved by itself");
  a_nmi_keeps_en: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (nmi_i && !wr && !chan0_tc_i && !chan1_tc_i)
    |=> ($stable(chan0_enable) && $stable(chan1_enable))) else $error("nmi touched a channel");

  // Terminal count: channel stops and reports
  a_tc_clears_ch1: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (chan1_tc_i && !wr) |=> !chan1_enable) else $error("ch1 not cleared on tc");
  a_tc0_stops_run: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (chan0_tc_i && !wr) |=> !chan0_run_o) else $error("ch0 still runs after tc");
  a_tc1_stops_run: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (chan1_tc_i && !wr) |=> !chan1_run_o) else $error("ch1 still runs after tc");
  a_tc0_raises_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (chan0_tc_i && !wr && chan0_done_irq_enable) |=> dma_irq_o)
    else $error("no irq after ch0 tc");
  a_tc1_raises_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (chan1_tc_i && !wr && chan1_done_irq_enable) |=> dma_irq_o)
    else $error("no irq after ch1 tc");

  // Bus answer: one ack or err per request, read data only with ack
  a_ack_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken_mapped |=> (wb_ack_o && !wb_err_o))
    else $error("mapped access not acked");
  a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken_unmapped |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");
  a_answer_once: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o)) else $error("answer held too long");
  a_rdata_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000)) else $error("read data outside ack");
  a_bus_state_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_state == DCES_IDLE) || (bus_state == DCES_ACK)) else $error("bus state illegal");
  a_lane_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_taken_mapped ##0 (wb_we_i && !wb_sel_i[0]))
    |=> ($stable(chan0_done_irq_enable) && $stable(chan1_done_irq_enable)))
    else $error("write without lane 0 took effect");
endmodule

// ==== verification/dces_cpu_model.sv ====
`timescale 1ns/10ps
// Processor side: classic single Wishbone cycles toward the status register
module dces_cpu_model (
  input wire logic clk_i, // System clock
  input wire logic ack_i, // Slave acknowledge
  input wire logic err_i, // Slave error
  input wire logic [31:0] dat_i, // Read data
  output logic cyc_o, // Cycle
  output logic stb_o, // Strobe
  output logic we_o, // Write
  output logic [7:0] adr_o, // Address
  output logic [31:0] dat_o, // Write data
  output logic [3:0] sel_o // Byte selects
);
  // Bus idle at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'hff;
    dat_o = 32'h0000_0000;
    sel_o = 4'h0;
  end

  // One access; software writes the guard as zero only to change an enable
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        input logic [3:0] sel, output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    dat_o <= wd;
    sel_o <= sel;
    do @(posedge clk_i); while (ack_i !== 1'b1 && err_i !== 1'b1);
    rd = dat_i;
    err = err_i;
    // Released address and write data show the inverse so stale values are never trusted
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr;
    dat_o <= ~wd;
  endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`include "dces_regs.svh"
module tb;
  logic clk_i, rst_i, nmi_i, tc0, tc1, cyc, stb, we, ack, err, run0, run1, irq, er;
  logic [7:0] adr;
  logic [31:0] wd, rdat, rd;
  logic [3:0] sel;
  int errors = 0;
  int checks_done = 0;

  dces_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .nmi_i(nmi_i), .chan0_tc_i(tc0), .chan1_tc_i(tc1),
    .chan0_run_o(run0), .chan1_run_o(run1), .dma_irq_o(irq));
  dces_cpu_model u_cpu (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wd), .sel_o(sel));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    u_cpu.access(1'b1, `DCES_STATUS_ADDR, {24'h00_0000, d}, 4'h1, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    u_cpu.access(1'b0, `DCES_STATUS_ADDR, 32'h0000_0000, 4'hf, rd, er);
    check(rd, {24'h00_0000, exp});
  endtask

  // Outputs settle after the edge: order is run1, run0, irq
  task automatic outs(input logic [2:0] exp);
    #1;
    check({29'h0000_0000, run1, run0, irq}, {29'h0000_0000, exp});
  endtask

  // One-cycle pulse: 0 nmi, 1 channel 0 count done, 2 channel 1 count done
  task automatic pulse(input int n);
    @(posedge clk_i);
    nmi_i <= (n == 0);
    tc0 <= (n == 1);
    tc1 <= (n == 2);
    @(posedge clk_i);
    nmi_i <= 1'b0;
    tc0 <= 1'b0;
    tc1 <= 1'b0;
  endtask

  task automatic t_enables();
    rd_chk(8'h32);
    outs(3'b000);
    wr(8'h60);
    rd_chk(8'h73);
    outs(3'b010);
    wr(8'hb0);
    rd_chk(8'h73);
    wr(8'h90);
    rd_chk(8'hf3);
    outs(3'b110);
    wr(8'h10);
    rd_chk(8'h73);
    wr(8'h90);
    rd_chk(8'hf3);
    $display("test enables done");
  endtask

  task automatic t_irq();
    wr(8'h3c);
    rd_chk(8'hff);
    outs(3'b110);
    pulse(1);
    outs(3'b101);
    wr(8'h38);
    outs(3'b100);
    pulse(2);
    outs(3'b001);
    wr(8'h30);
    outs(3'b000);
    rd_chk(8'h33);
    $display("test irq done");
  endtask

  task automatic t_nmi();
    wr(8'hc0);
    outs(3'b110);
    pulse(0);
    outs(3'b000);
    rd_chk(8'hf2);
    wr(8'h31);
    rd_chk(8'hf2);
    wr(8'hc0);
    rd_chk(8'hf3);
    wr(8'h20);
    rd_chk(8'hb3);
    outs(3'b100);
    $display("test nmi done");
  endtask

  // Unmapped address, lane disabled write, then reset with both channels enabled
  task automatic t_misc();
    u_cpu.access(1'b1, 8'h04, 32'h0000_0000, 4'h1, rd, er);
    check({31'h0000_0000, er}, 32'h0000_0001);
    u_cpu.access(1'b1, `DCES_STATUS_ADDR, 32'h0000_0000, 4'h0, rd, er);
    rd_chk(8'hb3);
    // Guarded set, count done and nmi in one cycle: the write and nmi both win
    fork
      wr(8'h60);
      begin
        @(posedge clk_i);
        nmi_i <= 1'b1;
        tc0 <= 1'b1;
        @(posedge clk_i);
        nmi_i <= 1'b0;
        tc0 <= 1'b0;
      end
    join
    rd_chk(8'hf2);
    outs(3'b000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h32);
    outs(3'b000);
    $display("test misc done");
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    nmi_i = 1'b0;
    tc0 = 1'b0;
    tc1 = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_enables();
    t_irq();
    t_nmi();
    t_misc();
    test_done();
  end

  // Tests need about a hundred cycles; a hang is cut off well beyond that
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule
